// ==== verilog/split_txn_and_power_capability_regs.sv ====
// Split transaction capability/limit registers and power management capability header
//
// How it works
// - Upstream register bits 15:0 read the upstream completion buffer capacity.
// - Downstream register bits 15:0 read the downstream completion buffer capacity.
// - Both capacity fields are constant 0010h: 16 ADQs, 2K bytes.
// - Bits 31:16 of each split register are a writable ADQ commitment limit.
// - A limit of FFFFh forwards every split request regardless of free space.
// - Limits reset to 0010h and accept any written value.
// - Requests exceeding downstream limit are delayed; sticky flag set, cleared by the delayed_clear input.
// - Power capability ID byte reads 01h, read-only.
// - Next capability link reads A8h, read-only.
// - Version field bits 18:16 reads 011.
// - Bit 19 reads 0: no clock needed for power events.
// - Bits 21 and 20 read 0.
// - Auxiliary current field bits 24:22 reads 001 (55 mA).
// - Bits 25 and 26 read 0: D1 and D2 unsupported.
// - Event support field bits 31:27 reads 11001.
`timescale 1ns/1ps
module split_txn_and_power_capability_regs #(
    parameter int LIMIT_W = 16
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic cfg_wr,
    input wire logic cfg_rd,
    input wire logic [7:0] cfg_addr,
    input wire logic [3:0] cfg_be,
    input wire logic [31:0] cfg_wdata,
    output logic [31:0] cfg_rdata,
    input wire logic delayed_clear,
    input wire logic dn_req_valid,
    input wire logic [LIMIT_W-1:0] dn_req_size,
    input wire logic [LIMIT_W-1:0] dn_in_use,
    output logic dn_req_forward,
    output logic dn_req_delay,
    input wire logic [LIMIT_W-1:0] up_req_size,
    input wire logic [LIMIT_W-1:0] up_in_use,
    output logic up_req_allow,
    output logic split_delayed,
    output logic [LIMIT_W-1:0] up_limit,
    output logic [LIMIT_W-1:0] dn_limit
);
    // ------------------------------------------------------------
    // Commitment limits
    // ------------------------------------------------------------
    logic [LIMIT_W-1:0] up_limit_r;
    logic [LIMIT_W-1:0] dn_limit_r;
    logic split_delayed_r;
    logic dn_allow;
    logic [31:0] rdata_r;

    // Byte enables 2 and 3 gate each byte of the limit; low half is capacity and never stored
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            up_limit_r <= cap_regs_pkg::LIMIT_RESET;
        end else if (cfg_wr && cfg_addr == cap_regs_pkg::OFS_UP_SPLIT) begin
            if (cfg_be[2]) begin
                up_limit_r[7:0] <= cfg_wdata[23:16];
            end
            if (cfg_be[3]) begin
                up_limit_r[15:8] <= cfg_wdata[31:24];
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            dn_limit_r <= cap_regs_pkg::LIMIT_RESET;
        end else if (cfg_wr && cfg_addr == cap_regs_pkg::OFS_DN_SPLIT) begin
            if (cfg_be[2]) begin
                dn_limit_r[7:0] <= cfg_wdata[23:16];
            end
            if (cfg_be[3]) begin
                dn_limit_r[15:8] <= cfg_wdata[31:24];
            end
        end
    end

    assign up_limit = up_limit_r;
    assign dn_limit = dn_limit_r;

    // ------------------------------------------------------------
    // Forwarding admission
    // ------------------------------------------------------------
    split_room_check #(.W(LIMIT_W)) dn_check (
        .limit(dn_limit_r),
        .in_use(dn_in_use),
        .req_size(dn_req_size),
        .allow(dn_allow)
    );

    split_room_check #(.W(LIMIT_W)) up_check (
        .limit(up_limit_r),
        .in_use(up_in_use),
        .req_size(up_req_size),
        .allow(up_req_allow)
    );

    assign dn_req_forward = dn_req_valid && dn_allow;
    assign dn_req_delay = dn_req_valid && !dn_allow;

    // Set wins over a same-cycle clear so no delay event is lost
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            split_delayed_r <= 1'b0;
        end else if (dn_req_delay) begin
            split_delayed_r <= 1'b1;
        end else if (delayed_clear) begin
            split_delayed_r <= 1'b0;
        end
    end

    assign split_delayed = split_delayed_r;

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    // Read data is registered; unmapped offsets return zero
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_r <= 32'h00000000;
        end else if (cfg_rd) begin
            if (cfg_addr == cap_regs_pkg::OFS_UP_SPLIT) begin
                rdata_r <= {up_limit_r, cap_regs_pkg::SPLIT_CAPACITY};
            end else if (cfg_addr == cap_regs_pkg::OFS_DN_SPLIT) begin
                rdata_r <= {dn_limit_r, cap_regs_pkg::SPLIT_CAPACITY};
            end else if (cfg_addr == cap_regs_pkg::OFS_PM_CAP) begin
                rdata_r <= {cap_regs_pkg::PM_EVENT_SUPPORT,
                            cap_regs_pkg::PM_D2_SUPPORT,
                            cap_regs_pkg::PM_D1_SUPPORT,
                            cap_regs_pkg::PM_AUX_CURRENT,
                            cap_regs_pkg::PM_DEV_INIT,
                            cap_regs_pkg::PM_RESERVED,
                            cap_regs_pkg::PM_CLOCK_NEEDED,
                            cap_regs_pkg::PM_VERSION,
                            cap_regs_pkg::PM_NEXT_LINK,
                            cap_regs_pkg::PM_CAP_ID};
            end else begin
                rdata_r <= 32'h00000000;
            end
        end
    end

    assign cfg_rdata = rdata_r;
endmodule

// ==== include/cap_regs_pkg.sv ====
// Package: offsets, field layouts and reset values of the split and power capability registers
package cap_regs_pkg;
    localparam logic [7:0] OFS_UP_SPLIT = 8'h88;
    localparam logic [7:0] OFS_DN_SPLIT = 8'h8C;
    localparam logic [7:0] OFS_PM_CAP = 8'h90;
    localparam logic [15:0] SPLIT_CAPACITY = 16'h0010;
    localparam logic [15:0] LIMIT_RESET = 16'h0010;
    localparam logic [15:0] LIMIT_UNLIMITED = 16'hFFFF;
    localparam logic [7:0] PM_CAP_ID = 8'h01;
    localparam logic [7:0] PM_NEXT_LINK = 8'hA8;
    localparam logic [2:0] PM_VERSION = 3'h3;
    localparam logic [0:0] PM_CLOCK_NEEDED = 1'h0;
    localparam logic [0:0] PM_RESERVED = 1'h0;
    localparam logic [0:0] PM_DEV_INIT = 1'h0;
    localparam logic [2:0] PM_AUX_CURRENT = 3'h1;
    localparam logic [0:0] PM_D1_SUPPORT = 1'h0;
    localparam logic [0:0] PM_D2_SUPPORT = 1'h0;
    localparam logic [4:0] PM_EVENT_SUPPORT = 5'h19;
    localparam int LIMIT_LSB = 16;
    localparam int LIMIT_MSB = 31;
    localparam int DELAYED_BIT = 21;
endpackage

// ==== verilog/split_room_check.sv ====
// Split request admission check against a commitment limit
`timescale 1ns/1ps
module split_room_check #(
    parameter int W = 16
) (
    input wire logic [W-1:0] limit,
    input wire logic [W-1:0] in_use,
    input wire logic [W-1:0] req_size,
    output logic allow
);
    logic [W:0] total;
    always_comb begin
        total = {1'b0, in_use} + {1'b0, req_size};
        // All-ones limit forwards everything regardless of space
        if (limit == {W{1'b1}}) begin
            allow = 1'b1;
        end else begin
            allow = (total <= {1'b0, limit});
        end
    end
endmodule

// ==== verif/cap_regs_asserts.sv ====
// Checker for the split limit and power capability registers
`timescale 1ns/1ps
module cap_regs_asserts #(parameter int LIMIT_W = 16) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic cfg_wr,
    input wire logic cfg_rd,
    input wire logic [7:0] cfg_addr,
    input wire logic [3:0] cfg_be,
    input wire logic [31:0] cfg_wdata,
    input wire logic [31:0] cfg_rdata,
    input wire logic delayed_clear,
    input wire logic dn_req_valid,
    input wire logic [LIMIT_W-1:0] dn_req_size,
    input wire logic [LIMIT_W-1:0] dn_in_use,
    input wire logic dn_req_forward,
    input wire logic dn_req_delay,
    input wire logic split_delayed,
    input wire logic [LIMIT_W-1:0] dn_limit
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // ----------------
    // Properties
    // ----------------
    chk_pm_header: assert property (
        cfg_rd && cfg_addr == 8'h90 |=> cfg_rdata == 32'hC843A801)
        else $error("power header mismatch");
    chk_cap_field: assert property (
        cfg_rd && cfg_addr[7:3] == 5'h11 |=> cfg_rdata[15:0] == 16'h0010)
        else $error("capacity mismatch");
    chk_limit_read: assert property (
        cfg_rd && !cfg_wr && cfg_addr == 8'h8C |=> cfg_rdata[31:16] == $past(dn_limit))
        else $error("limit readback");
    chk_limit_write: assert property (
        cfg_wr && cfg_addr == 8'h8C && cfg_be == 4'hF |=> dn_limit == $past(cfg_wdata[31:16]))
        else $error("limit write");
    chk_ro_write: assert property (
        cfg_wr && cfg_addr != 8'h8C |=> $stable(dn_limit))
        else $error("limit changed");
    chk_no_limit: assert property (
        dn_req_valid && dn_limit == 16'hFFFF |-> dn_req_forward)
        else $error("unlimited not forwarded");
    // A 17-bit sum so that a wrap cannot pass as a fit
    chk_fit_rule: assert property (
        dn_req_valid && dn_limit != 16'hFFFF |-> dn_req_delay ==
        ({1'b0, dn_in_use} + dn_req_size > {1'b0, dn_limit})) else $error("fit");
    chk_flag_set: assert property (
        dn_req_delay |=> split_delayed) else $error("flag");
    chk_flag_hold: assert property (
        split_delayed && !delayed_clear |=> split_delayed)
        else $error("flag dropped");
    cov_delay: cover property (dn_req_delay);
    cov_pm_read: cover property (cfg_rd && cfg_addr == 8'h90);
    cov_clear: cover property (split_delayed ##1 !split_delayed);
endmodule
bind split_txn_and_power_capability_regs cap_regs_asserts #(.LIMIT_W(LIMIT_W)) asserts_i (
    .ref_clk, .rst_n, .cfg_wr, .cfg_rd, .cfg_addr, .cfg_be, .cfg_wdata, .cfg_rdata,
    .delayed_clear, .dn_req_valid, .dn_req_size, .dn_in_use, .dn_req_forward, .dn_req_delay,
    .split_delayed, .dn_limit);

// ==== verif/tb_top.sv ====
// Testbench for the split limit and power capability registers
`timescale 1ns/1ps
module tb_top;
    logic ref_clk = 1'b0, rst_n = 1'b0, cfg_wr = 1'b0, cfg_rd = 1'b0, delayed_clear = 1'b0;
    logic dn_req_valid = 1'b0, dn_req_forward, dn_req_delay, up_req_allow, split_delayed;
    logic [7:0] cfg_addr = 8'h00;
    logic [3:0] cfg_be = 4'h0;
    logic [31:0] cfg_wdata = 32'h0, cfg_rdata;
    logic [15:0] dn_req_size = 16'h0, dn_in_use = 16'h0, up_req_size = 16'h0, up_in_use = 16'h0;
    logic [15:0] up_limit, dn_limit;
    int mismatches = 0, tests_run = 0;
    always #50 ref_clk = ~ref_clk;
    split_txn_and_power_capability_regs #(.LIMIT_W(16)) split_txn_and_power_capability_regs_i (
        .ref_clk, .rst_n, .cfg_wr, .cfg_rd, .cfg_addr, .cfg_be, .cfg_wdata, .cfg_rdata,
        .delayed_clear, .dn_req_valid, .dn_req_size, .dn_in_use, .dn_req_forward, .dn_req_delay,
        .up_req_size, .up_in_use, .up_req_allow, .split_delayed, .up_limit, .dn_limit);
    // ----------------
    // Tasks
    // ----------------
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // One access; for a read, d is the expected data
    task xfer(input logic w, input logic [7:0] a, input logic [3:0] b, input logic [31:0] d);
        @(posedge ref_clk);
        cfg_wr <= w;
        cfg_rd <= !w;
        cfg_addr <= a;
        cfg_be <= b;
        cfg_wdata <= d;
        @(posedge ref_clk);
        cfg_wr <= 1'b0;
        cfg_rd <= 1'b0;
        @(negedge ref_clk);
        if (!w) chk(cfg_rdata, d);
    endtask
    // Same request sizes go to both directions
    task req(input logic v, input logic [15:0] s, input logic [15:0] u);
        @(posedge ref_clk);
        dn_req_valid <= v;
        dn_req_size <= s;
        dn_in_use <= u;
        up_req_size <= s;
        up_in_use <= u;
        @(negedge ref_clk);
    endtask
    task final_report;
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge ref_clk);
        rst_n <= 1'b1;
        xfer(1'b0, 8'h88, 4'h0, 32'h0010_0010);
        xfer(1'b0, 8'h8C, 4'h0, 32'h0010_0010);
        xfer(1'b0, 8'h90, 4'h0, 32'hC843_A801);
        xfer(1'b0, 8'h84, 4'h0, 32'h0000_0000);
        $display("test reset values done");
        xfer(1'b1, 8'h90, 4'hF, 32'hFFFF_FFFF);
        xfer(1'b0, 8'h90, 4'h0, 32'hC843_A801);
        xfer(1'b1, 8'h88, 4'hF, 32'hFFFF_1234);
        xfer(1'b0, 8'h88, 4'h0, 32'hFFFF_0010);
        xfer(1'b1, 8'h8C, 4'h4, 32'h12AB_0000);
        xfer(1'b0, 8'h8C, 4'h0, 32'h00AB_0010);
        $display("test writes done");
        req(1'b1, 16'h0008, 16'hFFFF);
        chk({dn_req_forward, dn_req_delay, up_req_allow}, 3'b011);
        req(1'b0, 16'h0000, 16'h0000);
        chk(split_delayed, 1'b1);
        @(posedge ref_clk);
        delayed_clear <= 1'b1;
        @(posedge ref_clk);
        delayed_clear <= 1'b0;
        @(negedge ref_clk);
        chk(split_delayed, 1'b0);
        xfer(1'b1, 8'h8C, 4'hF, 32'h0010_0000);
        xfer(1'b1, 8'h88, 4'hC, 32'h0010_0000);
        chk({up_limit, dn_limit}, 32'h0010_0010);
        req(1'b1, 16'h0008, 16'h0008);
        chk({dn_req_forward, dn_req_delay, up_req_allow}, 3'b101);
        req(1'b1, 16'h0009, 16'h0008);
        chk({dn_req_forward, dn_req_delay, up_req_allow}, 3'b010);
        xfer(1'b1, 8'h8C, 4'hF, 32'hFFFF_0000);
        req(1'b1, 16'hFFFF, 16'hFFFF);
        chk({dn_req_forward, dn_req_delay}, 2'b10);
        $display("test forwarding done");
        final_report();
    end
endmodule
